// ### hdl/baud_gen.v
// fractional baud generator, one tick per bit period
// assumes divisor inputs stay stable while run is high
`timescale 1ns/10ps
`default_nettype none
`include "uart_tx_consts.vh"
module baud_gen #(
    parameter INT_W = `DIV_INT_W,
    parameter FRAC_W = `DIV_FRAC_W
) (
    input wire pclk, // reference clock
    input wire presetn, // async reset, low
    input wire run, // counting enabled, low clears
    input wire [INT_W-1:0] div_int, // integer divisor
    input wire [FRAC_W-1:0] div_frac, // fraction in 64ths
    input wire oversample_select, // 1: 8 samples a bit
    output reg bit_tick // one-cycle pulse per bit period
);
    reg [INT_W:0] cnt_r;
    reg [INT_W:0] limit_r;
    reg [FRAC_W-1:0] acc_r;
    reg [`OS_CNT_W-1:0] os_r;
    wire [FRAC_W:0] acc_sum = {1'b0, acc_r} + {1'b0, div_frac};
    wire [INT_W:0] cnt_inc = cnt_r + {{INT_W{1'b0}}, 1'b1};
    wire [`OS_CNT_W-1:0] os_last = oversample_select ? `OS8_LAST : `OS16_LAST;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {(INT_W+1){1'b0}};
            limit_r <= {(INT_W+1){1'b0}};
            acc_r <= {FRAC_W{1'b0}};
            os_r <= {`OS_CNT_W{1'b0}};
            bit_tick <= 1'b0;
        end else if (!run) begin
            cnt_r <= {(INT_W+1){1'b0}};
            limit_r <= {1'b0, div_int};
            acc_r <= {FRAC_W{1'b0}};
            os_r <= {`OS_CNT_W{1'b0}};
            bit_tick <= 1'b0;
        end else if (cnt_inc >= limit_r) begin
            // one sample period done; carry of the fraction adds a clock
            cnt_r <= {(INT_W+1){1'b0}};
            acc_r <= acc_sum[FRAC_W-1:0];
            limit_r <= {1'b0, div_int} + {{INT_W{1'b0}}, acc_sum[FRAC_W]};
            if (os_r == os_last) begin
                os_r <= {`OS_CNT_W{1'b0}};
                bit_tick <= 1'b1;
            end else begin
                os_r <= os_r + {{(`OS_CNT_W-1){1'b0}}, 1'b1};
                bit_tick <= 1'b0;
            end
        end else begin
            cnt_r <= cnt_inc;
            bit_tick <= 1'b0;
        end
    end
endmodule // baud_gen
`default_nettype wire

// ### hdl/tx_queue.v
// first-in first-out queue between the register bus and the transmitter
// assumes depth is a power of two; head word comes out of a register
`timescale 1ns/10ps
`default_nettype none
module tx_queue #(
    parameter WIDTH = 8,
    parameter DEPTH = 8
) (
    input wire pclk, // bus clock
    input wire presetn, // async reset, low
    input wire in_valid, // push request
    output wire in_ready, // room for a word
    input wire [WIDTH-1:0] in_data, // word pushed
    output reg out_valid, // head word present
    input wire out_ready, // pop request
    output reg [WIDTH-1:0] out_data, // head word
    output wire full, // no room
    output wire empty // nothing stored
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW-1:0] rd_nxt = pop ? rd_ptr_r + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_r;
    wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign full = (count_r == DEPTH[AW:0]);
    assign empty = (count_r == {(AW+1){1'b0}});
    assign in_ready = ~full;

    always @(posedge pclk) begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            rd_ptr_r <= rd_nxt;
            count_r <= count_nxt;
            out_valid <= (count_nxt != {(AW+1){1'b0}});
            // bypass when the word just pushed becomes the head
            if (push && wr_ptr_r == rd_nxt)
                out_data <= in_data;
            else
                out_data <= mem[rd_nxt];
        end
    end
endmodule // tx_queue
`default_nettype wire

// ### hdl/uart_tx_line.v
// serial transmitter with fractional baud divisor and line control, reached over APB
// assumes pclk is also the serial reference clock; APB master on the same clock
//
// Functional notes
// - divisor is clock over 16 or 8 times baud
// - divisor is integer plus six-bit fraction
// - new divisors apply only between characters
// - break drives line low after current character
// - break leaves queued characters untouched
// - parity bit sent only when parity enabled
// - even select 0 odd, 1 even parity
// - even select ignored with parity disabled
// - stop select 0 one, 1 two stops
// - oversample bit selects 16 or 8 samples a bit
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "uart_tx_consts.vh"
module uart_tx_line #(
    parameter FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire pclk, // bus and reference clock
    input wire presetn, // async reset, low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [`ADDR_W-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error, unmapped address
    output reg txd // serial transmit line
);
    // -----------------------------------------------------------------
    // states
    // -----------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_DATA = 3'h2;
    localparam [2:0] S_PARITY = 3'h3;
    localparam [2:0] S_STOP1 = 3'h4;
    localparam [2:0] S_STOP2 = 3'h5;
    localparam [2:0] S_BREAK = 3'h6;

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function addr_known;
        input [`ADDR_W-1:0] a;
        begin
            addr_known = (a == `OFS_TX_DATA) || (a == `OFS_STATUS) || (a == `OFS_DIV_INT) ||
                         (a == `OFS_DIV_FRAC) || (a == `OFS_LINE_CTRL) || (a == `OFS_CTRL);
        end
    endfunction

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    reg [`DIV_INT_W-1:0] div_int_r;
    reg [`DIV_FRAC_W-1:0] div_frac_r;
    reg [`LC_W-1:0] line_ctrl_r;
    reg oversample_r;
    reg [`DIV_INT_W-1:0] div_int_act_r;
    reg [`DIV_FRAC_W-1:0] div_frac_act_r;
    reg oversample_act_r;
    reg [2:0] state_r;
    reg [`DATA_W-1:0] shift_r;
    reg [2:0] bit_idx_r;
    reg parity_r;
    reg pen_r;
    reg stp2_r;
    reg [31:0] rd_val;
    wire bit_tick;
    wire q_in_ready;
    wire q_out_valid;
    wire [`DATA_W-1:0] q_out_data;
    wire q_full;
    wire q_empty;

    wire setup_done = psel & penable;
    wire complete = setup_done & pready;
    wire data_addr = (paddr == `OFS_TX_DATA);
    wire push_stall = pwrite & data_addr & ~q_in_ready;
    wire launch = setup_done & ~pready & ~push_stall;
    wire wr = complete & pwrite;
    wire send_break = line_ctrl_r[`LC_BRK];
    wire idle = (state_r == S_IDLE);
    wire can_start = idle & ~send_break & q_out_valid & (div_int_act_r != `RST_DIV_INT);
    wire q_pop = can_start;

    // -----------------------------------------------------------------
    // transmit queue
    // -----------------------------------------------------------------
    tx_queue #(
        .WIDTH(`DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr & data_addr),
        .in_ready(q_in_ready),
        .in_data(pwdata[`DATA_W-1:0]),
        .out_valid(q_out_valid),
        .out_ready(q_pop),
        .out_data(q_out_data),
        .full(q_full),
        .empty(q_empty)
    );

    // -----------------------------------------------------------------
    // baud generator, running only while a frame or break is on the line
    // -----------------------------------------------------------------
    baud_gen #(
        .INT_W(`DIV_INT_W),
        .FRAC_W(`DIV_FRAC_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(~idle),
        .div_int(div_int_act_r),
        .div_frac(div_frac_act_r),
        .oversample_select(oversample_act_r),
        .bit_tick(bit_tick)
    );

    // -----------------------------------------------------------------
    // register read mux, reserved bits read zero
    // -----------------------------------------------------------------
    always @* begin
        rd_val = 32'h00000000;
        case (paddr)
            `OFS_DIV_INT: begin
                rd_val[`DIV_INT_W-1:0] = div_int_r;
            end
            `OFS_DIV_FRAC: begin
                rd_val[`DIV_FRAC_W-1:0] = div_frac_r;
            end
            `OFS_LINE_CTRL: begin
                rd_val[`LC_W-1:0] = line_ctrl_r;
            end
            `OFS_CTRL: begin
                rd_val[`CTRL_OVS] = oversample_r;
            end
            `OFS_STATUS: begin
                rd_val[`ST_EMPTY] = q_empty;
                rd_val[`ST_FULL] = q_full;
                rd_val[`ST_BUSY] = ~idle;
                rd_val[`ST_BREAK] = (state_r == S_BREAK);
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // APB slave: ready one cycle after the access phase opens, later for a data write to a full queue
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            // a data write to a full queue waits here until a slot frees
            pready <= launch;
            if (launch) begin
                prdata <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= ~addr_known(paddr);
            end else if (complete) begin
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // software registers
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_int_r <= `RST_DIV_INT;
            div_frac_r <= `RST_DIV_FRAC;
            line_ctrl_r <= `RST_LC;
            oversample_r <= `RST_OVS;
        end else if (wr) begin
            case (paddr)
                `OFS_DIV_INT: begin
                    div_int_r <= pwdata[`DIV_INT_W-1:0];
                end
                `OFS_DIV_FRAC: begin
                    div_frac_r <= pwdata[`DIV_FRAC_W-1:0];
                end
                `OFS_LINE_CTRL: begin
                    line_ctrl_r <= pwdata[`LC_W-1:0];
                end
                `OFS_CTRL: begin
                    oversample_r <= pwdata[`CTRL_OVS];
                end
                default: begin
                    line_ctrl_r <= line_ctrl_r;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // divisor in use: copied only while no character is on the line
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_int_act_r <= `RST_DIV_INT;
            div_frac_act_r <= `RST_DIV_FRAC;
            oversample_act_r <= `RST_OVS;
        end else if (idle) begin
            div_int_act_r <= div_int_r;
            div_frac_act_r <= div_frac_r;
            oversample_act_r <= oversample_r;
        end
    end

    // -----------------------------------------------------------------
    // frame sequencer
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            txd <= 1'b1;
            shift_r <= {`DATA_W{1'b0}};
            bit_idx_r <= 3'h0;
            parity_r <= 1'b0;
            pen_r <= 1'b0;
            stp2_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    txd <= 1'b1;
                    if (send_break) begin
                        // only entered between characters; queue is not popped
                        state_r <= S_BREAK;
                        txd <= 1'b0;
                    end else if (can_start) begin
                        state_r <= S_START;
                        txd <= 1'b0;
                        shift_r <= q_out_data;
                        bit_idx_r <= 3'h0;
                        pen_r <= line_ctrl_r[`LC_PEN];
                        stp2_r <= line_ctrl_r[`LC_STP2];
                        // even select is a don't-care unless pen is set
                        parity_r <= line_ctrl_r[`LC_EPS] ? ^q_out_data : ~^q_out_data;
                    end
                end
                S_START: begin
                    if (bit_tick) begin
                        state_r <= S_DATA;
                        txd <= shift_r[0];
                        shift_r <= shift_r >> 1;
                    end
                end
                S_DATA: begin
                    if (bit_tick) begin
                        if (bit_idx_r == `DATA_LAST) begin
                            if (pen_r) begin
                                state_r <= S_PARITY;
                                txd <= parity_r;
                            end else begin
                                state_r <= S_STOP1;
                                txd <= 1'b1;
                            end
                        end else begin
                            bit_idx_r <= bit_idx_r + 3'h1;
                            txd <= shift_r[0];
                            shift_r <= shift_r >> 1;
                        end
                    end
                end
                S_PARITY: begin
                    if (bit_tick) begin
                        state_r <= S_STOP1;
                        txd <= 1'b1;
                    end
                end
                S_STOP1: begin
                    if (bit_tick) begin
                        state_r <= stp2_r ? S_STOP2 : S_IDLE;
                    end
                end
                S_STOP2: begin
                    if (bit_tick) begin
                        state_r <= S_IDLE;
                    end
                end
                S_BREAK: begin
                    // line held low in whole bit periods; software keeps it a frame long
                    txd <= 1'b0;
                    if (bit_tick && !send_break) begin
                        state_r <= S_STOP1; // a stop-length mark follows the break
                        txd <= 1'b1;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                    txd <= 1'b1;
                end
            endcase
        end
    end
endmodule // uart_tx_line
`default_nettype wire

// ### include/uart_tx_consts.vh
// constants of the serial transmitter
// assumes inclusion by bare name
`ifndef UART_TX_CONSTS_VH
`define UART_TX_CONSTS_VH

// ---------------------------------------------------------------------
// register map (byte addresses), fields and reset values
// ---------------------------------------------------------------------
`define ADDR_W 12
`define OFS_TX_DATA 12'h000
`define OFS_STATUS 12'h018
`define OFS_DIV_INT 12'h024
`define OFS_DIV_FRAC 12'h028
`define OFS_LINE_CTRL 12'h02C
`define OFS_CTRL 12'h030
`define DIV_INT_W 16
`define DIV_FRAC_W 6
`define LC_W 4
`define LC_BRK 0
`define LC_PEN 1
`define LC_EPS 2
`define LC_STP2 3
`define CTRL_OVS 3
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_BUSY 2
`define ST_BREAK 3
`define RST_DIV_INT 16'h0000
`define RST_DIV_FRAC 6'h00
`define RST_LC 4'h0
`define RST_OVS 1'b0

// ---------------------------------------------------------------------
// frame and timing
// ---------------------------------------------------------------------
`define DATA_W 8
`define FIFO_DEPTH 8
`define DATA_LAST 3'h7
`define OS_CNT_W 4
`define OS16_LAST 4'hF
`define OS8_LAST 4'h7

`endif

// ### test/serial_peer.sv
// behavioural far-end receiver: samples the line mid-bit and reports each frame
// assumes its settings change only between frames
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
    input wire logic pclk, // reference clock
    input wire logic txd, // line from the transmitter
    input wire logic [15:0] bit_clks, // clocks per bit
    input wire logic par_en, // expect a parity bit
    input wire logic two_stop, // expect two stop bits
    output logic rx_done, // one-cycle pulse per frame
    output logic [9:0] rx_word, // stop ok, parity, data
    output int low_len // length of the last low run
);
    int n;
    int cnt = 0;
    logic [7:0] dat;
    logic par, stop_ok, pe, ts;
    always @(posedge pclk) begin
        if (txd === 1'b0) begin
            cnt <= cnt + 1;
        end else begin
            if (cnt != 0) low_len <= cnt;
            cnt <= 0;
        end
    end
    // settings latched at the start edge
    initial begin
        rx_done = 1'b0;
        rx_word = 10'h000;
        forever begin
            @(negedge txd);
            n = bit_clks;
            pe = par_en;
            ts = two_stop;
            repeat (n / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (n) @(posedge pclk);
                dat[i] = txd;
            end
            par = 1'b0;
            if (pe) begin
                repeat (n) @(posedge pclk);
                par = txd;
            end
            repeat (n) @(posedge pclk);
            stop_ok = txd;
            if (ts) begin
                repeat (n) @(posedge pclk);
                stop_ok = stop_ok & txd;
            end
            // zeros with a low stop: a break
            if (dat == 8'h00 && !stop_ok) begin
                wait (txd === 1'b1);
            end else begin
                rx_word <= {stop_ok, par, dat};
                rx_done <= 1'b1;
                @(posedge pclk);
                rx_done <= 1'b0;
            end
        end
    end
endmodule // serial_peer
`default_nettype wire

// ### test/uart_tx_line_assertions.sv
// checker of the transmitter's bus handshake, readback and line timing
// assumes binding into uart_tx_line
`timescale 1ns/10ps
`default_nettype none
`include "uart_tx_consts.vh"
module uart_tx_line_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // bus select
    input wire logic penable, // access phase
    input wire logic pwrite, // write
    input wire logic [`ADDR_W-1:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic txd // serial line
);
    logic [5:0] frac_sh_r;
    logic [3:0] lc_sh_r;
    wire mapped;
    wire rd_done;
    assign mapped = (paddr == `OFS_TX_DATA) || (paddr == `OFS_STATUS) || (paddr == `OFS_DIV_INT) ||
        (paddr == `OFS_DIV_FRAC) || (paddr == `OFS_LINE_CTRL) || (paddr == `OFS_CTRL);
    assign rd_done = psel && penable && pready && !pwrite;
    // --------
    // shadow copies of what software last wrote
    // --------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frac_sh_r <= 6'h00;
            lc_sh_r <= 4'h0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == `OFS_DIV_FRAC)
                frac_sh_r <= pwdata[5:0];
            if (paddr == `OFS_LINE_CTRL)
                lc_sh_r <= pwdata[3:0];
        end
    end
    // --------
    // properties
    // --------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable && paddr != `OFS_TX_DATA; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    property p_one_wait; s_setup |=> s_wait ##1 pready; endproperty
    property p_ready_in_access; pready |-> psel && penable; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_idle_rdata; !pready |-> prdata == 32'h00000000; endproperty
    property p_err_map; pready |-> pslverr == !mapped; endproperty
    property p_frac_rd; rd_done && paddr == `OFS_DIV_FRAC |-> prdata == {26'h0000000, frac_sh_r}; endproperty
    property p_lc_rd; rd_done && paddr == `OFS_LINE_CTRL |-> prdata == {28'h0000000, lc_sh_r}; endproperty
    property p_after_rst; $rose(presetn) |-> txd && !pready; endproperty
    property p_low_run; $fell(txd) |-> (!txd) [*8]; endproperty
    property p_high_run; $rose(txd) |-> txd [*8]; endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data not zero");
    a_err_map: assert property (p_err_map) else $error("error flag wrong");
    a_frac_rd: assert property (p_frac_rd) else $error("fraction readback");
    a_lc_rd: assert property (p_lc_rd) else $error("line control readback");
    a_after_rst: assert property (p_after_rst) else $error("line busy after reset");
    a_low_run: assert property (p_low_run) else $error("low bit too short");
    a_high_run: assert property (p_high_run) else $error("high bit too short");
endmodule // uart_tx_line_checker

bind uart_tx_line uart_tx_line_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd));
`default_nettype wire

// ### test/uart_tx_line_tb.sv
// self-checking bench for uart_tx_line
// assumes the checker is bound in its own file
`timescale 1ns/10ps
`default_nettype none
`include "uart_tx_consts.vh"
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module uart_tx_line_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] bit_clks;
    logic par_en, even_sel, two_stop, rx_done;
    logic [9:0] rx_word;
    logic [7:0] d;
    logic [64:0] e_r;
    logic [64:0] rd_q[$];
    logic [9:0] fr_q[$];
    int low_len;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 76015;
    uart_tx_line #(.FIFO_DEPTH(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txd(txd));
    serial_peer i_peer (.pclk(pclk), .txd(txd), .bit_clks(bit_clks), .par_en(par_en), .two_stop(two_stop),
        .rx_done(rx_done), .rx_word(rx_word), .low_len(low_len));
    always #5 pclk = ~pclk;
    // --------
    // result watcher
    // --------
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e_r = rd_q.pop_front();
            `CHECK_EQ({pslverr, prdata & e_r[63:32]}, {e_r[64], e_r[31:0]})
        end
        if (rx_done) begin
            e_r = {55'h0, fr_q.pop_front()};
            `CHECK_EQ(rx_word, e_r[9:0])
        end
    end
    // --------
    // tasks
    // --------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic err);
        rd_q.push_back({err, mask, exp});
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic send(input logic [7:0] b);
        fr_q.push_back({1'b1, par_en ? (even_sel ? ^b : ~^b) : 1'b0, b});
        apb(1'b1, `OFS_TX_DATA, {24'h000000, b});
    endtask
    task automatic set_lc(input logic [3:0] lc);
        apb(1'b1, `OFS_LINE_CTRL, {28'h0000000, lc});
        par_en = lc[1];
        even_sel = lc[2];
        two_stop = lc[3];
    endtask
    task automatic drain;
        while (fr_q.size() != 0) @(posedge pclk);
        repeat (3 * bit_clks) @(posedge pclk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    // --------
    // main sequence
    // --------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        bit_clks = 16'h0014;
        par_en = 1'b0;
        even_sel = 1'b0;
        two_stop = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_DIV_FRAC, 32'hFFFFFFFF, 32'h00000000, 1'b0);
        rd(`OFS_LINE_CTRL, 32'hFFFFFFFF, 32'h00000000, 1'b0);
        apb(1'b1, `OFS_DIV_FRAC, 32'hFFFFFFFF);
        rd(`OFS_DIV_FRAC, 32'hFFFFFFFF, 32'h0000003F, 1'b0);
        apb(1'b1, `OFS_LINE_CTRL, 32'hFFFFFFFE);
        rd(`OFS_LINE_CTRL, 32'hFFFFFFFF, 32'h0000000E, 1'b0);
        rd(12'h100, 32'hFFFFFFFF, 32'h00000000, 1'b1);
        $display("test registers done");
        // 1.25 x 16 and 2.5 x 8 clocks: 20 a bit
        set_lc(4'h0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `OFS_DIV_INT, k ? 32'h00000002 : 32'h00000001);
            apb(1'b1, `OFS_DIV_FRAC, k ? 32'h00000020 : 32'h00000010);
            apb(1'b1, `OFS_CTRL, k ? 32'h00000008 : 32'h00000000);
            send(8'h00);
            drain();
            `CHECK_EQ(low_len >= 9 * bit_clks && low_len <= 9 * bit_clks + 2, 1'b1)
        end
        $display("test baud rate done");
        for (int m = 0; m < 8; m++) begin
            set_lc({m[2:0], 1'b0});
            repeat (2) begin
                d = $random(seed);
                send(d);
            end
            drain();
        end
        $display("test line modes done");
        send(8'hA5);
        send(8'h3C);
        @(negedge txd);
        apb(1'b1, `OFS_DIV_INT, 32'h00000003);
        bit_clks = 16'h001C;
        drain();
        $display("test divisor update done");
        set_lc(4'h0);
        for (int i = 0; i < 9; i++) begin
            d = $random(seed);
            send(d);
        end
        rd(`OFS_STATUS, 32'h0000000F, 32'h00000006, 1'b0);
        d = $random(seed);
        send(d);
        drain();
        rd(`OFS_STATUS, 32'h0000000F, 32'h00000001, 1'b0);
        $display("test queue full done");
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            send(d);
        end
        apb(1'b1, `OFS_LINE_CTRL, 32'h00000001);
        while (fr_q.size() > 2) @(posedge pclk);
        repeat (12 * bit_clks) @(posedge pclk);
        `CHECK_EQ(txd, 1'b0)
        rd(`OFS_STATUS, 32'h00000009, 32'h00000008, 1'b0);
        apb(1'b1, `OFS_LINE_CTRL, 32'h00000000);
        drain();
        $display("test break done");
        finish_test();
    end
endmodule // uart_tx_line_tb
`default_nettype wire
